// ### ccp_pkg.sv
// Package for the capture/compare/PWM mode select block: offsets, fields, modes.
// Assumes a plain address/strobe register port with 8-bit data.
package ccp_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] ctrl_off = 3'h0;
  localparam logic [2:0] duty_high_off = 3'h1;
  localparam logic [2:0] cap_low_off = 3'h2;
  localparam logic [2:0] cap_high_off = 3'h3;
  localparam logic [2:0] status_off = 3'h4;
  localparam logic [2:0] timer_sel_off = 3'h5;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int mode_lsb = 0;
  localparam int frac_lsb = 4;
  localparam int cfg_lsb = 6;
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] duty_rst = 8'h00;
  localparam logic [15:0] cap_rst = 16'h0000;
  localparam logic [1:0] timer_sel_rst = 2'h0;
  localparam logic [3:0] presc_rst = 4'h0;
  localparam logic [3:0] presc_4_max = 4'h3;
  localparam logic [3:0] presc_16_max = 4'hf;
  // ----------------------------------------
  // Mode select encodings
  // ----------------------------------------
  typedef enum logic [3:0] {
    mode_off = 4'h0,
    mode_rsv1 = 4'h1,
    mode_cmp_toggle = 4'h2,
    mode_rsv3 = 4'h3,
    mode_cap_fall = 4'h4,
    mode_cap_rise = 4'h5,
    mode_cap_rise4 = 4'h6,
    mode_cap_rise16 = 4'h7,
    mode_cmp_set = 4'h8,
    mode_cmp_clr = 4'h9,
    mode_cmp_soft = 4'ha,
    mode_cmp_trig = 4'hb,
    mode_pwm_hh = 4'hc,
    mode_pwm_hl = 4'hd,
    mode_pwm_lh = 4'he,
    mode_pwm_ll = 4'hf
  } mode_select_t;
endpackage

// ### ccp_mode_select.sv
// Mode select, capture path and compare pin actions of a capture/compare/PWM unit.
// Assumes pin and timer inputs are synchronous to clk_i; PWM waveform comes from outside.
//
// Functional notes
// - PWM duty is duty_high_register bits above the two duty_fraction_bits.
// - Mode 0000 turns the unit off and resets it; 0001, 0011 reserved.
// - Mode 0010 toggles the pin on every compare match.
// - Mode 0100 captures falling edges, 0101 rising edges.
// - Mode 0110 captures every 4th rising edge, 0111 every 16th.
// - Mode 1000 starts pin low, drives high on match, sets flag.
// - Mode 1001 starts pin high, drives low on match, sets flag.
// - Mode 1010 only sets the flag; pin returns to port function.
// - Mode 1011 resets assigned timer, requests conversion, sets flag on match.
// - Modes 11xx are PWM; bit1 inverts A and C, bit0 inverts B, D.
// - Up to four PWM outputs, enabled by output config and mode.
// - Capture/compare use first or third timer; PWM uses timebase timer.
// - Timer-select bits in third timer control choose capture/compare timer.
// - Each capture copies full 16-bit timer count into capture register.
// - Flag set on every event, held until software clears it; the code sets no flag on a mode 0010 toggle match.
// - A new capture overwrites an unread earlier value.
// - Port latch writes moving an output pin can cause a capture.
// - A capture mode change may raise a spurious capture.
// - Prescale counter clears when off or capture mode is left.
// - Output config selects single, forward, half-bridge or reverse bridge.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ccp_mode_select (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pin and timers
  input wire logic pin_level_i,
  input wire logic [15:0] first_timer_count_i,
  input wire logic [15:0] third_timer_count_i,
  input wire logic compare_match_i,
  input wire logic pwm_raw_i,
  // Outputs
  output logic pin_out_o,
  output logic pin_owned_o,
  output logic timer1_reset_o,
  output logic timer3_reset_o,
  output logic adc_start_o,
  output logic event_flag_o,
  output logic [9:0] duty_value_o,
  output logic [3:0] pwm_out_o,
  output logic [3:0] pwm_en_o,
  output logic use_pwm_timer_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] duty_q;
  logic [15:0] cap_q;
  logic flag_q;
  logic [1:0] tsel_q;
  logic [3:0] presc_q;
  logic pin_prev_q;
  logic cmp_pin_q;
  logic [3:0] mode_prev_q;
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [3:0] mode = ctrl_q[ccp_pkg::mode_lsb +: 4];
  wire [1:0] frac = ctrl_q[ccp_pkg::frac_lsb +: 2];
  wire [1:0] cfg = ctrl_q[ccp_pkg::cfg_lsb +: 2];
  wire is_cap = (mode[3:2] == 2'h1);
  wire is_pwm = (mode[3:2] == 2'h3);
  wire is_cmp = (mode == ccp_pkg::mode_cmp_toggle) || (mode[3:2] == 2'h2);
  wire was_cap = (mode_prev_q[3:2] == 2'h1);
  wire mode_changed = (mode != mode_prev_q);
  // Third timer selected when tsel bit set
  wire use_third = tsel_q[0];
  wire [15:0] tb_count = use_third ? third_timer_count_i : first_timer_count_i;
  // Edges seen on pin, including port-latch driven changes
  wire rise = pin_level_i & ~pin_prev_q;
  wire fall = ~pin_level_i & pin_prev_q;
  wire [3:0] presc_max = (mode == ccp_pkg::mode_cap_rise16) ?
                         ccp_pkg::presc_16_max : ccp_pkg::presc_4_max;
  wire presc_mode = (mode == ccp_pkg::mode_cap_rise4) || (mode == ccp_pkg::mode_cap_rise16);
  wire presc_wrap = rise && (presc_q >= presc_max);
  // Capture trigger by mode
  wire cap_evt = (mode == ccp_pkg::mode_cap_fall) ? fall :
                 (mode == ccp_pkg::mode_cap_rise) ? rise :
                 presc_mode ? presc_wrap : 1'b0;
  wire cmp_evt = is_cmp && compare_match_i;
  wire flag_cmp = cmp_evt && (mode != ccp_pkg::mode_cmp_toggle);
  wire trig_evt = cmp_evt && (mode == ccp_pkg::mode_cmp_trig);
  wire wr_ctrl = wr_i && (addr_i == ccp_pkg::ctrl_off);
  wire wr_stat = wr_i && (addr_i == ccp_pkg::status_off);
  // Entering 1000 or 1001 presets the pin
  wire enter_set = mode_changed && (mode == ccp_pkg::mode_cmp_set);
  wire enter_clr = mode_changed && (mode == ccp_pkg::mode_cmp_clr);
  logic cmp_pin_d;
  always_comb begin
    cmp_pin_d = cmp_pin_q;
    if (mode == ccp_pkg::mode_off) begin
      cmp_pin_d = 1'b0;
    end else if (enter_set) begin
      cmp_pin_d = 1'b0;
    end else if (enter_clr) begin
      cmp_pin_d = 1'b1;
    end else if (cmp_evt && mode == ccp_pkg::mode_cmp_toggle) begin
      cmp_pin_d = ~cmp_pin_q;
    end else if (cmp_evt && mode == ccp_pkg::mode_cmp_set) begin
      cmp_pin_d = 1'b1;
    end else if (cmp_evt && mode == ccp_pkg::mode_cmp_clr) begin
      cmp_pin_d = 1'b0;
    end
  end
  // Pin ownership: capture and soft-interrupt leave the pin to the port
  wire owned_d = (mode == ccp_pkg::mode_cmp_toggle) || (mode == ccp_pkg::mode_cmp_set) ||
                 (mode == ccp_pkg::mode_cmp_clr) || (mode == ccp_pkg::mode_cmp_trig);
  // PWM output mapping
  wire pol_ac = mode[1];
  wire pol_bd = mode[0];
  logic [3:0] act;
  logic [3:0] en;
  always_comb begin
    act = 4'h0;
    en = 4'h0;
    case (cfg)
      2'h0: begin
        act = {4{pwm_raw_i}};
        en = 4'h1;
      end
      2'h1: begin
        act = {pwm_raw_i, 1'b0, 1'b0, 1'b1};
        en = 4'hf;
      end
      2'h2: begin
        act = {1'b0, 1'b0, ~pwm_raw_i, pwm_raw_i};
        en = 4'h3;
      end
      default: begin
        act = {1'b0, 1'b1, pwm_raw_i, 1'b0};
        en = 4'hf;
      end
    endcase
  end
  wire [3:0] pwm_d = act ^ {pol_bd, pol_ac, pol_bd, pol_ac};
  wire [7:0] rd_mux = (addr_i == ccp_pkg::ctrl_off) ? ctrl_q :
                      (addr_i == ccp_pkg::duty_high_off) ? duty_q :
                      (addr_i == ccp_pkg::cap_low_off) ? cap_q[7:0] :
                      (addr_i == ccp_pkg::cap_high_off) ? cap_q[15:8] :
                      (addr_i == ccp_pkg::status_off) ? {7'h00, flag_q} :
                      (addr_i == ccp_pkg::timer_sel_off) ? {6'h00, tsel_q} : 8'h00;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= ccp_pkg::ctrl_rst;
      duty_q <= ccp_pkg::duty_rst;
      tsel_q <= ccp_pkg::timer_sel_rst;
      rdata_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_i;
      end
      if (wr_i && addr_i == ccp_pkg::duty_high_off) begin
        duty_q <= wdata_i;
      end
      if (wr_i && addr_i == ccp_pkg::timer_sel_off) begin
        tsel_q <= wdata_i[1:0];
      end
      rdata_q <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Capture, flag and prescaler
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_q <= ccp_pkg::cap_rst;
      flag_q <= 1'b0;
      presc_q <= ccp_pkg::presc_rst;
      pin_prev_q <= 1'b0;
      mode_prev_q <= 4'h0;
    end else begin
      pin_prev_q <= pin_level_i;
      mode_prev_q <= mode;
      if (is_cap && cap_evt) begin
        cap_q <= tb_count;
      end else if (wr_i && addr_i == ccp_pkg::cap_low_off) begin
        cap_q[7:0] <= wdata_i;
      end else if (wr_i && addr_i == ccp_pkg::cap_high_off) begin
        cap_q[15:8] <= wdata_i;
      end
      // Set wins over a software clear in the same cycle
      if ((is_cap && cap_evt) || flag_cmp) begin
        flag_q <= 1'b1;
      end else if (wr_stat && !wdata_i[0]) begin
        flag_q <= 1'b0;
      end
      // Prescaler not cleared between capture submodes, only when off or left
      if (!is_cap || (was_cap && !is_cap)) begin
        presc_q <= ccp_pkg::presc_rst;
      end else if (rise) begin
        presc_q <= presc_wrap ? ccp_pkg::presc_rst : presc_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_pin_q <= 1'b0;
      pin_owned_o <= 1'b0;
      timer1_reset_o <= 1'b0;
      timer3_reset_o <= 1'b0;
      adc_start_o <= 1'b0;
      duty_value_o <= 10'h000;
      pwm_out_o <= 4'h0;
      pwm_en_o <= 4'h0;
      use_pwm_timer_o <= 1'b0;
    end else begin
      cmp_pin_q <= cmp_pin_d;
      pin_owned_o <= owned_d;
      timer1_reset_o <= trig_evt && !use_third;
      timer3_reset_o <= trig_evt && use_third;
      adc_start_o <= trig_evt;
      duty_value_o <= {duty_q, frac};
      pwm_out_o <= is_pwm ? pwm_d : 4'h0;
      pwm_en_o <= is_pwm ? en : 4'h0;
      use_pwm_timer_o <= is_pwm;
    end
  end
  assign pin_out_o = cmp_pin_q;
  assign event_flag_o = flag_q;
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ### ccp_checker.sv
// Assertions on the mode select block outputs.
// Assumes binding to ccp_mode_select; mirrors control writes itself.
`timescale 1ns/1ns
`default_nettype none
module ccp_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic compare_match_i,
  input wire logic pin_out_o,
  input wire logic pin_owned_o,
  input wire logic timer1_reset_o,
  input wire logic timer3_reset_o,
  input wire logic adc_start_o,
  input wire logic event_flag_o,
  input wire logic [9:0] duty_value_o,
  input wire logic use_pwm_timer_o
);
  // ------
  // Mirror
  // ------
  logic [7:0] ctl_q;
  logic [7:0] dh_q;
  logic sel_q;
  logic [1:0] age_q;
  wire logic [3:0] m = ctl_q[3:0];
  // Settled two edges after a write, so derived flops may lag
  wire logic st = age_q == 2'h2;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_q <= 8'h00;
      dh_q <= 8'h00;
      sel_q <= 1'b0;
      age_q <= 2'h2;
    end else begin
      if (wr_i && addr_i == 3'h0) ctl_q <= wdata_i;
      if (wr_i && addr_i == 3'h1) dh_q <= wdata_i;
      if (wr_i && addr_i == 3'h5) sel_q <= wdata_i[0];
      age_q <= wr_i ? 2'h0 : (st ? 2'h2 : age_q + 2'h1);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_duty_join: assert property (
    st |-> duty_value_o == {dh_q, ctl_q[5:4]}) else $error("duty");
  a_off_idle: assert property (
    st && (m == 4'h0 || m == 4'h1 || m == 4'h3) |-> !pin_owned_o && !pin_out_o) else $error("idle");
  a_toggle_match: assert property (
    st && m == 4'h2 && compare_match_i |=> pin_out_o != $past(pin_out_o)) else $error("toggle");
  a_set_high: assert property (
    st && m == 4'h8 && compare_match_i |=> pin_out_o && event_flag_o) else $error("set");
  a_clear_low: assert property (
    st && m == 4'h9 && compare_match_i |=> !pin_out_o && event_flag_o) else $error("clear");
  a_soft_flag: assert property (
    st && m == 4'ha && compare_match_i |=> event_flag_o && !pin_owned_o) else $error("soft");
  a_event_trig: assert property (
    st && m == 4'hb && compare_match_i |=> adc_start_o && (sel_q ? timer3_reset_o : timer1_reset_o))
    else $error("trigger");
  a_pwm_timer: assert property (
    st |-> use_pwm_timer_o == (m[3:2] == 2'b11)) else $error("timebase");
  a_flag_hold: assert property (
    event_flag_o && !wr_i |=> event_flag_o) else $error("flag");
  cover property (st && m == 4'h5 && $rose(event_flag_o));
  cover property (adc_start_o);
  cover property (st && m == 4'hf);
endmodule
bind ccp_mode_select ccp_checker chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .compare_match_i(compare_match_i), .pin_out_o(pin_out_o),
  .pin_owned_o(pin_owned_o), .timer1_reset_o(timer1_reset_o), .timer3_reset_o(timer3_reset_o),
  .adc_start_o(adc_start_o), .event_flag_o(event_flag_o), .duty_value_o(duty_value_o),
  .use_pwm_timer_o(use_pwm_timer_o));
`default_nettype wire

// ### pin_model.sv
// External signal on the capture pin.
// Assumes one bench command per edge: 1 rise, 2 fall.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input wire logic clk_i,
  input wire logic [1:0] cmd_i,
  output logic pin_o
);
  // Pin is a synchronous input and only moves on command
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (cmd_i == 2'h1) pin_o <= 1'b1;
    if (cmd_i == 2'h2) pin_o <= 1'b0;
  end
endmodule
`default_nettype wire

// ### tb_capture_compare_mode_select.sv
// Self-checking bench for ccp_mode_select.
// Assumes pin_model and ccp_checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module tb_capture_compare_mode_select;
  logic clk_i = '0, rst_i = '1, w = '0, r = '0, mt = '0, raw = '0;
  logic [2:0] a = '0;
  logic [7:0] wd = '0, v, hi, c;
  logic [1:0] cmd = '0;
  logic [15:0] t1 = '0, t3 = '0;
  logic [3:0] m;
  wire logic pin, po, own, r1, r3, adc, flag, up;
  wire logic [7:0] rdata;
  wire logic [9:0] duty;
  wire logic [3:0] pout, pen;
  integer seed = 32'he453, mismatches = 0, num_checks = 0, cycles = 0, i, k, n;
  logic [3:0] cm [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int cn [4] = '{1, 1, 4, 16};
  logic [3:0] pm [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  ccp_mode_select dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(a), .wdata_i(wd), .wr_i(w),
    .rd_i(r), .rdata_o(rdata), .pin_level_i(pin), .first_timer_count_i(t1),
    .third_timer_count_i(t3), .compare_match_i(mt), .pwm_raw_i(raw), .pin_out_o(po),
    .pin_owned_o(own), .timer1_reset_o(r1), .timer3_reset_o(r3), .adc_start_o(adc),
    .event_flag_o(flag), .duty_value_o(duty), .pwm_out_o(pout), .pwm_en_o(pen),
    .use_pwm_timer_o(up));
  pin_model far (.clk_i(clk_i), .cmd_i(cmd), .pin_o(pin));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  task complete_run();
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // ------
  // Bus and pin drivers
  // ------
  task wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    a <= ad;
    wd <= d;
    w <= '1;
    @(posedge clk_i);
    w <= '0;
    @(negedge clk_i);
  endtask
  task rd(input logic [2:0] ad, output logic [7:0] q);
    @(posedge clk_i);
    a <= ad;
    r <= '1;
    @(posedge clk_i);
    r <= '0;
    @(negedge clk_i);
    q = rdata;
  endtask
  // Timers move only with a rise, so both edges of a pulse see one value
  task pin_to(input logic [1:0] pc);
    @(posedge clk_i);
    cmd <= pc;
    if (pc == 2'h1) begin
      t1 <= 16'($random(seed));
      t3 <= 16'($random(seed));
    end
    @(posedge clk_i);
    cmd <= '0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic [3:0] en_of(input logic [1:0] g);
    return g == 2'b00 ? 4'h1 : (g == 2'b10 ? 4'h3 : 4'hf);
  endfunction
  function automatic logic [3:0] val_of(input logic [3:0] s, input logic x);
    logic [3:0] y;
    case (s[3:2])
      2'b00: y = {3'b000, x};
      2'b01: y = {x, 3'b001};
      2'b10: y = {2'b00, ~x, x};
      default: y = {2'b01, x, 1'b0};
    endcase
    return y ^ {s[0], s[1], s[0], s[1]};
  endfunction
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= '0;
    wr(3'h7, 8'hff);
    for (i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      chk(v, 16'h0000);
    end
    foreach (cm[j]) begin
      wr(3'h0, 8'h00);
      wr(3'h5, {7'h00, j[0]});
      wr(3'h0, {4'h0, cm[j]});
      wr(3'h4, 8'h00);
      for (n = 0; n < 2; n++)
        for (k = 0; k < cn[j]; k++) begin
          chk(flag, 16'(n));
          pin_to(2'h1);
          pin_to(2'h2);
        end
      chk(flag, 16'h0001);
      rd(3'h2, v);
      rd(3'h3, hi);
      chk({hi, v}, j[0] ? t3 : t1);
      wr(3'h4, 8'h00);
      chk(flag, 16'h0000);
    end
    foreach (pm[j]) begin
      m = pm[j];
      wr(3'h0, 8'h00);
      wr(3'h5, {7'h00, j[0]});
      wr(3'h0, {4'h0, m});
      wr(3'h4, 8'h00);
      if (m == 4'h8 || m == 4'h9) chk(po, m[0]);
      @(posedge clk_i) mt <= '1;
      @(posedge clk_i) mt <= '0;
      @(negedge clk_i);
      if (m < 4'ha) chk(po, m == 4'h2 || m == 4'h8);
      chk(flag, m > 4'h7);
      chk({own, adc, r1, r3}, {m == 4'h2 || m[3:1] == 3'h4 || m == 4'hb, m == 4'hb,
        m == 4'hb && !j[0], m == 4'hb && j[0]});
    end
    for (i = 0; i < 16; i++) begin
      k = $random(seed);
      c = {i[3:2], k[1:0], 2'b11, i[1:0]};
      wr(3'h1, k[15:8]);
      wr(3'h0, c);
      @(posedge clk_i) raw <= k[4];
      rd(3'h0, v);
      chk(v, c);
      chk(duty, {k[15:8], k[1:0]});
      chk(up, 16'h0001);
      chk(pen, en_of(c[7:6]));
      chk(pout & pen, val_of(i[3:0], k[4]) & pen);
    end
    complete_run();
  end
endmodule
`default_nettype wire
